// >>> hw/pebc_top.sv
// pwm enable and brightness control core with register port
//
// Added by the designer: strobed register access and the placing of the registers.
`include "pebc_defs.svh"
module pebc_top #(
    parameter int unsigned HOLD_CYCLES = `PEBC_HOLD_CYCLES,
    parameter int unsigned DUTY_SHIFT  = `PEBC_DUTY_SHIFT
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    input  wire logic                  hardware_enable_pin,
    // pwm pin
    input  wire logic                  pwm_in,
    // register port
    input  wire pebc_pkg::pebc_byte_type reg_addr,
    input  wire pebc_pkg::pebc_byte_type reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output      pebc_pkg::pebc_byte_type reg_rdata,
    // led current control
    output      pebc_pkg::pebc_frac_type led_level,
    output      pebc_pkg::pebc_fs_type   full_scale_led_current,
    output      logic                  output_on
);
    import pebc_pkg::*;
    localparam int AW = 16 + DUTY_SHIFT;

    if (DUTY_SHIFT < 1 || DUTY_SHIFT > 16) begin : g_chk
        $error("duty filter shift out of range");
    end

    // enable pin low acts as a reset of the whole block
    wire rst_all = srst || !hardware_enable_pin;

    pebc_core_if cif ();

    pebc_level_qual #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_qual (
        .clk_sys (clk_sys),
        .srst    (rst_all),
        .q       (cif.qual)
    );

    pebc_map_rom u_rom (
        .clk_sys (clk_sys),
        .m       (cif.rom)
    );

    pebc_byte_type  cfg_q;
    pebc_code_type  brt_q;
    pebc_state_type st_q;
    pebc_state_type st_d;
    logic [AW-1:0]  acc_q;
    logic [AW-1:0]  acc_d;
    pebc_frac_type  level_q;
    pebc_frac_type  level_d;
    pebc_fs_type    fs_q;
    logic           on_q;
    pebc_byte_type  rdata_q;
    pebc_byte_type  rdata_d;

    // register decode
    wire sel_cfg    = reg_addr == `PEBC_OFS_GEN_CFG;
    wire sel_brt    = reg_addr == `PEBC_OFS_BRT;
    wire sel_status = reg_addr == `PEBC_OFS_STATUS;
    wire sel_duty   = reg_addr == `PEBC_OFS_DUTY;
    wire sel_level  = reg_addr == `PEBC_OFS_LEVEL;
    wire wr_cfg     = reg_wr && sel_cfg;
    wire wr_brt     = reg_wr && sel_brt;

    // configuration fields
    wire simple_mode = cfg_q[`PEBC_BIT_SIMPLE] && cfg_q[`PEBC_BIT_PWM_EN];
    wire pol_inv     = cfg_q[`PEBC_BIT_POL];
    wire pwm_scale   = cfg_q[`PEBC_BIT_PWM_EN];
    wire map_linear  = cfg_q[`PEBC_BIT_MAP];
    wire bus_enable  = cfg_q[`PEBC_BIT_BUS_EN];

    // active sense of the pin after polarity
    wire pwm_active  = pwm_in ^ pol_inv;
    wire qual_active = cif.qual_level ^ pol_inv;

    assign cif.pwm_lvl  = pwm_in;
    assign cif.map_code = brt_q;
    assign cif.map_exp  = !map_linear;

    // on/off only moves on a qualified level, short pulses never reach here
    always_comb begin
        st_d = st_q;
        if (simple_mode && cif.qual_stb) begin
            case (qual_active)
                1'b1:    st_d = PEBC_ON;
                default: st_d = PEBC_SHUTDOWN;
            endcase
        end
    end

    wire on_w = simple_mode ? (st_q == PEBC_ON) : bus_enable;

    // first order filter of the active duty; slow enough for low ripple at kHz rates,
    // the trade is a settling time of several filter constants after a duty change
    wire [AW-1:0] target = {pwm_active ? `PEBC_FRAC_FULL : 16'h0000, {DUTY_SHIFT{1'b0}}};
    assign acc_d = acc_q - (acc_q >> DUTY_SHIFT) + (target >> DUTY_SHIFT);
    wire pebc_frac_type duty = acc_q[AW-1 -: 16];

    // fraction of full scale times filtered duty when pwm enable is set, no switching of the output
    wire [31:0]         prod   = cif.map_frac * duty;
    wire pebc_frac_type scaled = pwm_scale ? prod[31:16] : cif.map_frac;
    assign level_d = on_w ? scaled : 16'h0000;

    // read data, unmapped offsets read zero
    wire pebc_byte_type status = {5'h00, simple_mode, cif.qual_level, on_q};
    always_comb begin
        rdata_d = 8'h00;
        if (sel_cfg) begin
            rdata_d = cfg_q;
        end else if (sel_brt) begin
            rdata_d = {1'b0, brt_q};
        end else if (sel_status) begin
            rdata_d = status;
        end else if (sel_duty) begin
            rdata_d = duty[15:8];
        end else if (sel_level) begin
            rdata_d = level_q[15:8];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            cfg_q <= `PEBC_GEN_CFG_RST;
            brt_q <= `PEBC_BRT_RST;
        end else begin
            cfg_q <= wr_cfg ? reg_wdata : cfg_q;
            brt_q <= wr_brt ? reg_wdata[6:0] : brt_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            st_q    <= PEBC_SHUTDOWN;
            acc_q   <= '0;
            level_q <= 16'h0000;
            fs_q    <= 3'h0;
            on_q    <= 1'b0;
        end else begin
            st_q    <= st_d;
            acc_q   <= acc_d;
            level_q <= level_d;
            fs_q    <= cfg_q[`PEBC_FS_HI:`PEBC_FS_LO];
            on_q    <= on_w;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rdata_d : 8'h00;
        end
    end

    assign reg_rdata              = rdata_q;
    assign led_level              = level_q;
    assign full_scale_led_current = fs_q;
    assign output_on              = on_q;

    a_mode_gate: assert property (@(posedge clk_sys) disable iff (rst_all)
        !(cfg_q[`PEBC_BIT_SIMPLE] && cfg_q[`PEBC_BIT_PWM_EN]) |=> st_q == $past(st_q))
        else $error("state moved outside simple enable mode");

    a_high_turns_on: assert property (@(posedge clk_sys) disable iff (rst_all)
        (simple_mode && !pol_inv && cif.qual_stb && cif.qual_level)
        |=> st_q == PEBC_ON ##1 output_on)
        else $error("held high did not turn on");

    a_low_shuts_down: assert property (@(posedge clk_sys) disable iff (rst_all)
        (simple_mode && !pol_inv && cif.qual_stb && !cif.qual_level)
        |=> st_q == PEBC_SHUTDOWN ##1 (!output_on && led_level == 16'h0000))
        else $error("held low did not shut down");

    a_inverted_sense: assert property (@(posedge clk_sys) disable iff (rst_all)
        (simple_mode && pol_inv && cif.qual_stb)
        |=> st_q == (cif.qual_level ? PEBC_SHUTDOWN : PEBC_ON))
        else $error("inverted polarity not honoured");

    a_hold_between: assert property (@(posedge clk_sys) disable iff (rst_all)
        !cif.qual_stb |=> $stable(st_q))
        else $error("state changed without a qualified level");

    a_cfg_default: assert property (@(posedge clk_sys)
        rst_all |=> cfg_q == 8'hCC && brt_q == 7'h7F)
        else $error("registers not at default after reset");

    a_pin_reset: assert property (@(posedge clk_sys)
        (!hardware_enable_pin && !srst) |=> (st_q == PEBC_SHUTDOWN && !output_on))
        else $error("enable pin low did not reset");

    a_duty_scales: assert property (@(posedge clk_sys) disable iff (rst_all)
        (on_w && pwm_scale) |=> led_level == $past(prod[31:16]))
        else $error("level not scaled by duty");

    a_fs_field: assert property (@(posedge clk_sys) disable iff (rst_all)
        wr_cfg ##1 !wr_cfg |=> full_scale_led_current == $past(reg_wdata[4:2], 2))
        else $error("full scale field not taken");

    c_turn_on: cover property (@(posedge clk_sys) disable iff (rst_all)
        simple_mode && st_q == PEBC_SHUTDOWN ##1 st_q == PEBC_ON);
    c_shut_down: cover property (@(posedge clk_sys) disable iff (rst_all)
        simple_mode && st_q == PEBC_ON ##1 st_q == PEBC_SHUTDOWN);
    c_pulsed_mid: cover property (@(posedge clk_sys) disable iff (rst_all)
        output_on && duty > 16'h4000 && duty < 16'hC000);
    c_inverted_on: cover property (@(posedge clk_sys) disable iff (rst_all)
        pol_inv && simple_mode && st_q == PEBC_ON);
endmodule : pebc_top

// >>> hw/pebc_defs.svh
// offsets, field positions, reset values and timing counts of the brightness control
`ifndef PEBC_DEFS_SVH
`define PEBC_DEFS_SVH

`define PEBC_OFS_GEN_CFG   8'h00
`define PEBC_OFS_BRT       8'h01
`define PEBC_OFS_STATUS    8'h02
`define PEBC_OFS_DUTY      8'h03
`define PEBC_OFS_LEVEL     8'h04

`define PEBC_BIT_SIMPLE    7
`define PEBC_BIT_POL       6
`define PEBC_BIT_PWM_EN    5
`define PEBC_FS_HI         4
`define PEBC_FS_LO         2
`define PEBC_BIT_MAP       1
`define PEBC_BIT_BUS_EN    0

`define PEBC_GEN_CFG_RST   8'hCC
`define PEBC_BRT_RST       7'h7F

`define PEBC_CLK_KHZ       20000
`define PEBC_HOLD_US       2000
`define PEBC_HOLD_CYCLES   ((`PEBC_HOLD_US * `PEBC_CLK_KHZ + 999) / 1000)
`define PEBC_DUTY_SHIFT    12

`define PEBC_FRAC_FULL     16'hFFFF
`define PEBC_LIN_SHIFT     9
`define PEBC_EXP_STEP      61983

`endif

// >>> hw/pebc_pkg.sv
// types shared by the brightness control modules
package pebc_pkg;
    typedef logic [7:0]  pebc_byte_type;
    typedef logic [6:0]  pebc_code_type;
    typedef logic [15:0] pebc_frac_type;
    typedef logic [2:0]  pebc_fs_type;
    typedef enum logic { PEBC_SHUTDOWN, PEBC_ON } pebc_state_type;
endpackage : pebc_pkg

// >>> hw/pebc_core_if.sv
// signals between the core, the level qualifier and the mapping table
interface pebc_core_if;
    import pebc_pkg::*;
    logic           pwm_lvl;
    logic           qual_stb;
    logic           qual_level;
    pebc_code_type  map_code;
    logic           map_exp;
    pebc_frac_type  map_frac;

    modport core (output pwm_lvl, output map_code, output map_exp,
                  input qual_stb, input qual_level, input map_frac);
    modport qual (input pwm_lvl, output qual_stb, output qual_level);
    modport rom  (input map_code, input map_exp, output map_frac);
endinterface : pebc_core_if

// >>> hw/pebc_level_qual.sv
// hold timer that qualifies a level of the pwm input
`include "pebc_defs.svh"
module pebc_level_qual #(
    parameter int unsigned HOLD_CYCLES = `PEBC_HOLD_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // core side
    pebc_core_if.qual q
);
    import pebc_pkg::*;
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    if (HOLD_CYCLES < 2) begin : g_chk
        $error("hold count too small");
    end

    logic          prev_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          stb_q;
    logic          lvl_q;

    wire changed = q.pwm_lvl != prev_q;
    wire at_hold = cnt_q == CW'(HOLD_CYCLES);
    wire stb_d   = !changed && cnt_q == CW'(HOLD_CYCLES - 1);

    // any edge restarts the count, saturate once held
    assign cnt_d = changed ? '0 : (at_hold ? cnt_q : cnt_q + 1'b1);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prev_q <= 1'b0;
            cnt_q  <= '0;
            stb_q  <= 1'b0;
            lvl_q  <= 1'b0;
        end else begin
            prev_q <= q.pwm_lvl;
            cnt_q  <= cnt_d;
            stb_q  <= stb_d;
            lvl_q  <= stb_d ? prev_q : lvl_q;
        end
    end

    assign q.qual_stb   = stb_q;
    assign q.qual_level = lvl_q;

    a_edge_restart: assert property (@(posedge clk_sys) disable iff (srst)
        changed |=> cnt_q == '0)
        else $error("count not restarted on edge");
    a_stb_after_hold: assert property (@(posedge clk_sys) disable iff (srst)
        q.qual_stb |-> at_hold && q.qual_level == $past(q.pwm_lvl))
        else $error("level qualified before hold time");
endmodule : pebc_level_qual

// >>> hw/pebc_map_rom.sv
// brightness code to full scale fraction table, registered read
`include "pebc_defs.svh"
module pebc_map_rom (
    // clock
    input wire logic clk_sys,
    // core side
    pebc_core_if.rom m
);
    import pebc_pkg::*;

    // geometric steps of about 5.4 percent per code down from full scale
    function automatic pebc_frac_type exp_val(input int idx);
        longint v;
        v = 65535;
        for (int k = 127; k > idx; k--) begin
            v = (v * `PEBC_EXP_STEP) >>> 16;
        end
        return (idx == 0) ? 16'h0000 : v[15:0];
    endfunction : exp_val

    pebc_frac_type exp_tab [128];
    pebc_frac_type data_q;

    for (genvar i = 0; i < 128; i++) begin : g_tab
        assign exp_tab[i] = exp_val(i);
    end

    // linear steps of 1/128, code 0 is off, top code saturates to full
    wire [16:0]    lin_sh  = 17'({m.map_code, 9'h000}) + 17'(1 << `PEBC_LIN_SHIFT);
    wire           lin_ovf = lin_sh[16];
    pebc_frac_type lin_val;
    assign lin_val = (m.map_code == 7'h00) ? 16'h0000 :
                     (lin_ovf ? `PEBC_FRAC_FULL : lin_sh[15:0]);

    always_ff @(posedge clk_sys) begin
        data_q <= m.map_exp ? exp_tab[m.map_code] : lin_val;
    end

    assign m.map_frac = data_q;

    a_lin_code9: assert property (@(posedge clk_sys)
        (!m.map_exp && m.map_code == 7'h09) |=> data_q == 16'h1400)
        else $error("linear code 9 not 7.8 percent");
    a_full_top: assert property (@(posedge clk_sys)
        (m.map_code == 7'h7F) |=> data_q == `PEBC_FRAC_FULL)
        else $error("top code not full scale");
endmodule : pebc_map_rom

// >>> sim/pebc_pwm_host.sv
// host model that drives the pwm pin of the brightness control
module pebc_pwm_host (
    // clock
    input  wire logic clk_sys,
    // pwm pin
    output      logic pwm_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial pwm_in = 1'b0;

    // level held for about n edges, changed just after an edge
    task automatic hold(input logic v, input int n);
        @(posedge clk_sys);
        pwm_in <= v;
        repeat (n - 1) @(posedge clk_sys);
    endtask : hold

    // pulse train; lows kept short of the hold count so the output survives
    task automatic pulses(input int hi, input int lo, input int count);
        repeat (count) begin
            hold(1'b1, hi);
            hold(1'b0, lo);
        end
    endtask : pulses
endmodule : pebc_pwm_host

// >>> sim/test_pwm_enable_brightness_ctrl.sv
// self-checking bench for the pwm enable and brightness control
module test_pwm_enable_brightness_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import pebc_pkg::*;

    // short hold so the run stays brief
    localparam int HOLD = 20;

    logic          clk_sys;
    logic          srst;
    logic          hardware_enable_pin;
    logic          pwm_in;
    logic          reg_wr;
    logic          reg_rd;
    pebc_byte_type reg_addr;
    pebc_byte_type reg_wdata;
    pebc_byte_type reg_rdata;
    pebc_frac_type led_level;
    pebc_fs_type   full_scale_led_current;
    logic          output_on;
    int            fails;
    int            cmp_count;

    pebc_top #(.HOLD_CYCLES(HOLD), .DUTY_SHIFT(4)) dut_u (
        .clk_sys                (clk_sys),
        .srst                   (srst),
        .hardware_enable_pin    (hardware_enable_pin),
        .pwm_in                 (pwm_in),
        .reg_addr               (reg_addr),
        .reg_wdata              (reg_wdata),
        .reg_wr                 (reg_wr),
        .reg_rd                 (reg_rd),
        .reg_rdata              (reg_rdata),
        .led_level              (led_level),
        .full_scale_led_current (full_scale_led_current),
        .output_on              (output_on)
    );

    pebc_pwm_host host_u (
        .clk_sys (clk_sys),
        .pwm_in  (pwm_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // settle past the edge before looking
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        #1;
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input pebc_byte_type a, input pebc_byte_type d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe
    task automatic rd(input pebc_byte_type a, output pebc_byte_type d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // whole run is about 1200 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize;
    end

    initial begin
        pebc_byte_type d;
        fails = 0;
        cmp_count = 0;
        srst = 1'b1;
        hardware_enable_pin = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        rd(8'h00, d); chk(d, 8'hCC);
        rd(8'h01, d); chk(d, 8'h7F);
        rd(8'h07, d); chk(d, 8'h00);
        // read data stand one cycle only
        @(posedge clk_sys); chk(reg_rdata, 8'h00);
        chk(full_scale_led_current, 3'b011);
        // reset value leaves pwm enable clear, so the pin has no say
        host_u.hold(1'b1, HOLD + 10); chk(output_on, 1'b0);
        wr(8'h00, 8'hAC);
        host_u.hold(1'b0, HOLD + 10);
        host_u.hold(1'b1, HOLD - 5);
        host_u.hold(1'b0, 5); chk(output_on, 1'b0);
        host_u.hold(1'b1, HOLD); chk(output_on, 1'b0);
        host_u.hold(1'b1, 6); chk(output_on, 1'b1);
        rd(8'h02, d); chk(d, 8'h07);
        host_u.hold(1'b1, 200); chk(led_level[15:12], 4'hF);
        rd(8'h04, d); chk(d[7:4], 4'hF);
        host_u.pulses(10, 10, 15); chk(output_on, 1'b1);
        chk(led_level[15:8] inside {[8'h50:8'hB0]}, 1'b1);
        host_u.hold(1'b0, HOLD + 10); chk(output_on, 1'b0);
        chk(led_level, 16'h0000);
        wr(8'h00, 8'hAE);
        wr(8'h01, 8'h09);
        host_u.hold(1'b1, 300); chk(led_level[15:8] inside {[8'h13:8'h14]}, 1'b1);
        host_u.hold(1'b0, HOLD + 10);
        wr(8'h00, 8'hEC);
        wr(8'h01, 8'h7F);
        host_u.hold(1'b1, HOLD + 10); chk(output_on, 1'b0);
        host_u.hold(1'b0, HOLD + 10); chk(output_on, 1'b1);
        host_u.hold(1'b1, HOLD + 10); chk(output_on, 1'b0);
        // outside simple mode the bus enable bit rules
        wr(8'h00, 8'h2D);
        repeat (4) @(posedge clk_sys);
        chk(output_on, 1'b1);
        host_u.hold(1'b0, HOLD + 10); chk(output_on, 1'b1);
        for (int fs = 0; fs < 8; fs++) begin
            wr(8'h00, {3'b101, fs[2:0], 2'b00});
            repeat (3) @(posedge clk_sys);
            chk(full_scale_led_current, fs[2:0]);
        end
        @(posedge clk_sys);
        hardware_enable_pin <= 1'b0;
        @(posedge clk_sys);
        hardware_enable_pin <= 1'b1;
        rd(8'h00, d); chk(d, 8'hCC);
        rd(8'h01, d); chk(d, 8'h7F);
        summarize;
    end
endmodule : test_pwm_enable_brightness_ctrl
